// ### design/ref_gen_pkg.sv
package ref_gen_pkg;

    //////////////////////////////////////////////////////////////////////
    // clock and time base
    localparam int unsigned CLK_HZ          = 10_000_000;        // clk_sys rate
    localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000; // cycles per microsecond

    localparam int unsigned FILTER_US       = 150;               // line sense settle time
    localparam int unsigned FILTER_CYC      = FILTER_US * CLK_PER_US;
    localparam int unsigned STARTUP_MS      = 80;                // line sampling window
    localparam int unsigned STARTUP_CYC     = STARTUP_MS * 1000 * CLK_PER_US;
    localparam int unsigned MIN_HIGH_US     = 5900;              // shortest usable high pulse
    localparam int unsigned MIN_HIGH_CYC    = MIN_HIGH_US * CLK_PER_US;
    localparam int unsigned OVP_TIMEOUT_MS  = 1000;              // over-voltage hold-off
    localparam int unsigned OVP_TIMEOUT_CYC = OVP_TIMEOUT_MS * 1000 * CLK_PER_US;
    localparam int unsigned LOSS_MS         = 30;                // no falling edge for this long
    localparam int unsigned LOSS_CYC        = LOSS_MS * 1000 * CLK_PER_US;

    //////////////////////////////////////////////////////////////////////
    // reference codes, full scale 127 = 1 V
    localparam logic [6:0] REF_STARTUP  = 7'h32;  // 50
    localparam logic [6:0] REF_GROUNDED = 7'h32;  // 50
    localparam logic [6:0] REF_NOSENSE  = 7'h2A;  // 42
    localparam logic [6:0] REF_MIN      = 7'h16;  // 22
    localparam logic [6:0] REF_MAX      = 7'h7F;  // 127
    localparam logic [6:0] BLEND_LAST   = 7'h7F;  // 127 line cycles of blend
    localparam logic [8:0] SAMPLES      = 9'h100; // samples per line period
    localparam logic [14:0] RAMP_SPAN_FX = 15'h6900; // (127-22) in 7.8 fixed point

    //////////////////////////////////////////////////////////////////////
    // controller modes
    typedef enum logic [4:0] {
        ST_LOCKOUT  = 5'h01,
        ST_STARTUP  = 5'h02,
        ST_NORMAL   = 5'h04,
        ST_NOSENSE  = 5'h08,
        ST_GROUNDED = 5'h10
    } mode_t;

    // comparator and supply indications from the analog stage
    typedef struct packed {
        logic supply_ok;      // undervoltage lockout released
        logic current_trip;   // switch current has reached the reference
        logic off_time_done;  // constant off-time elapsed
        logic over_temp;      // thermal shutdown indication, analog hysteresis
        logic ovp_trip;       // supply_overvoltage_trip comparator
        logic ovp_release;    // supply 0.5 V below the trip level
    } stage_in_t;

endpackage

// ### design/sense_filter.sv
module sense_filter #(
    parameter int unsigned HOLD_CYC = 1500
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic raw,
    output logic      level_q
);

    logic [11:0] cnt_q;    // cycles the input has disagreed
    logic [11:0] cnt_d;
    logic        level_d;

    //////////////////////////////////////////////////////////////////////
    // flip only after the input disagrees for more than HOLD_CYC cycles
    always_comb begin
        cnt_d   = 12'h000;
        level_d = level_q;
        if (raw != level_q) begin
            if (cnt_q == 12'(HOLD_CYC)) begin
                level_d = raw;
            end else begin
                cnt_d = cnt_q + 12'h001;
            end
        end
    end

    // registers only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q   <= 12'h000;
            level_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            level_q <= level_d;
        end
    end

endmodule

// ### design/line_synced_reference_generator.sv
// Summary of operation
// - triangle peak centred in line-sense high interval
// - blend DC into ramp over 127 cycles
// - lost or narrow sense forces code 42
// - grounded sense gives constant code 50
// - over-temperature holds gate low until cleared
// - supply over-voltage pulls gate low
// - stay off until timeout and supply drop
// - outside the window hold code 22 once the blend is complete
// - end on-time when current reaches reference
// - period split in 256 samples, 127 levels
// - start at code 50, sample line 80 ms
// - accept sense change after 150 us stable
// - ramp only when high exceeds 5.9 ms
module line_synced_reference_generator #(
    parameter int unsigned STARTUP_CYC = ref_gen_pkg::STARTUP_CYC,
    parameter int unsigned MIN_HIGH_CYC = ref_gen_pkg::MIN_HIGH_CYC,
    parameter int unsigned OVP_TIMEOUT_CYC = ref_gen_pkg::OVP_TIMEOUT_CYC,
    parameter int unsigned LOSS_CYC = ref_gen_pkg::LOSS_CYC
) (
    input  wire logic                  clk_sys,
    input  wire logic                  arst_n,
    input  wire logic                  line_sense_input,
    input  wire ref_gen_pkg::stage_in_t stage_in,
    output logic [6:0]                 ref_code_q,
    output logic                       gate_drive_q
);

    // saturating 19-bit increment, used by the period and width counters
    function automatic logic [18:0] inc19(input logic [18:0] v);
        inc19 = (v == 19'h7FFFF) ? v : v + 19'h00001;
    endfunction

    //////////////////////////////////////////////////////////////////////
    // line sense filtering
    logic sense_f;  // filtered line sense level

    sense_filter #(
        .HOLD_CYC (ref_gen_pkg::FILTER_CYC)
    ) u_filter (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .raw      (line_sense_input),
        .level_q  (sense_f)
    );

    //////////////////////////////////////////////////////////////////////
    // line measurement, sample clock and triangle generator
    localparam logic [8:0]  SAMPLES_C   = ref_gen_pkg::SAMPLES;
    localparam logic [14:0] RAMP_SPAN_C = ref_gen_pkg::RAMP_SPAN_FX;
    localparam logic [6:0]  REF_MIN_C   = ref_gen_pkg::REF_MIN;
    localparam logic [6:0]  REF_MAX_C   = ref_gen_pkg::REF_MAX;

    logic        prev_q,     prev_d;      // last filtered level
    logic [18:0] per_cnt_q,  per_cnt_d;   // clocks since last fall
    logic [18:0] period_q,   period_d;    // last full period
    logic [18:0] high_cnt_q, high_cnt_d;  // clocks of present high
    logic        high_ok_q,  high_ok_d;   // last high pulse wide enough
    logic        seen_q,     seen_d;      // any edge at all
    logic [10:0] samp_cnt_q, samp_cnt_d;  // divider for the sample tick
    logic [7:0]  phase_q,    phase_d;     // sample index since fall
    logic [7:0]  rise_ph_q,  rise_ph_d;   // sample index of last rise
    logic [7:0]  half_q,     half_d;      // rise to peak in samples
    logic        win_q,      win_d;       // inside the high interval
    logic [7:0]  win_cnt_q,  win_cnt_d;   // samples since rise
    logic [14:0] acc_q,      acc_d;       // triangle, 7.8 fixed point
    logic [14:0] step_q,     step_d;      // triangle slope per sample
    logic [3:0]  div_cnt_q,  div_cnt_d;   // serial divider steps left
    logic [7:0]  div_rem_q,  div_rem_d;   // divider remainder
    logic [14:0] div_quo_q,  div_quo_d;   // dividend in, quotient out
    logic        rise, fall, tick;
    logic        fall_ok;                 // fall ending a wide pulse
    logic [10:0] interval;
    logic [8:0]  rem_sh;
    logic [8:0]  half_w;
    logic [15:0] acc_up;

    assign rise     = sense_f & ~prev_q;
    assign fall     = ~sense_f & prev_q;
    assign fall_ok  = fall & (high_cnt_q > 19'(MIN_HIGH_CYC));
    assign interval = (period_q[18:8] == 11'h000) ? 11'h001 : period_q[18:8];
    assign tick     = (samp_cnt_q + 11'h001 >= interval);

    // next state of the measurement and ramp group
    always_comb begin
        prev_d     = sense_f;
        per_cnt_d  = fall ? 19'h00000 : inc19(per_cnt_q);
        period_d   = fall ? inc19(per_cnt_q) : period_q;
        high_cnt_d = sense_f ? inc19(high_cnt_q) : 19'h00000;
        high_ok_d  = fall ? fall_ok : high_ok_q;
        seen_d     = seen_q | rise | fall;
        samp_cnt_d = (tick || fall) ? 11'h000 : samp_cnt_q + 11'h001;
        phase_d    = fall ? 8'h00 : (tick ? phase_q + 8'h01 : phase_q);
        rise_ph_d  = rise ? phase_q : rise_ph_q;
        half_w     = (SAMPLES_C - {1'b0, rise_ph_q}) >> 1;
        half_d     = half_q;
        win_d      = rise ? 1'b1 : (fall ? 1'b0 : win_q);
        win_cnt_d  = rise ? 8'h00 : ((tick && win_q) ? win_cnt_q + 8'h01 : win_cnt_q);
        acc_d      = acc_q;
        acc_up     = {1'b0, acc_q} + {1'b0, step_q};
        step_d     = step_q;
        div_cnt_d  = div_cnt_q;
        div_rem_d  = div_rem_q;
        div_quo_d  = div_quo_q;
        rem_sh     = {div_rem_q, div_quo_q[14]};
        // peak sits half the high width after the rise
        if (fall) begin
            half_d    = (half_w == 9'h000) ? 8'h01 : half_w[7:0];
            div_cnt_d = 4'hF;
            div_rem_d = 8'h00;
            div_quo_d = RAMP_SPAN_C;
        end else if (div_cnt_q != 4'h0) begin
            // restoring divider: span over half width gives the slope
            div_cnt_d = div_cnt_q - 4'h1;
            if (rem_sh >= {1'b0, half_q}) begin
                div_rem_d = 8'(rem_sh - {1'b0, half_q});
                div_quo_d = {div_quo_q[13:0], 1'b1};
            end else begin
                div_rem_d = rem_sh[7:0];
                div_quo_d = {div_quo_q[13:0], 1'b0};
            end
            if (div_cnt_q == 4'h1) begin
                step_d = div_quo_d;
            end
        end
        // triangle rises to the centre and falls back, clipped to its range
        if (!win_q || rise) begin
            acc_d = {REF_MIN_C, 8'h00};
        end else if (tick) begin
            if (win_cnt_q < half_q) begin
                acc_d = (acc_up > {1'b0, REF_MAX_C, 8'h00}) ? {REF_MAX_C, 8'h00} : acc_up[14:0];
            end else begin
                acc_d = (acc_q < step_q + {REF_MIN_C, 8'h00}) ? {REF_MIN_C, 8'h00} : acc_q - step_q;
            end
        end
    end

    // registers only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prev_q     <= 1'b0;
            per_cnt_q  <= 19'h00000;
            period_q   <= 19'h00000;
            high_cnt_q <= 19'h00000;
            high_ok_q  <= 1'b0;
            seen_q     <= 1'b0;
            samp_cnt_q <= 11'h000;
            phase_q    <= 8'h00;
            rise_ph_q  <= 8'h00;
            half_q     <= 8'h01;
            win_q      <= 1'b0;
            win_cnt_q  <= 8'h00;
            acc_q      <= {ref_gen_pkg::REF_MIN, 8'h00};
            step_q     <= 15'h0000;
            div_cnt_q  <= 4'h0;
            div_rem_q  <= 8'h00;
            div_quo_q  <= 15'h0000;
        end else begin
            prev_q     <= prev_d;
            per_cnt_q  <= per_cnt_d;
            period_q   <= period_d;
            high_cnt_q <= high_cnt_d;
            high_ok_q  <= high_ok_d;
            seen_q     <= seen_d;
            samp_cnt_q <= samp_cnt_d;
            phase_q    <= phase_d;
            rise_ph_q  <= rise_ph_d;
            half_q     <= half_d;
            win_q      <= win_d;
            win_cnt_q  <= win_cnt_d;
            acc_q      <= acc_d;
            step_q     <= step_d;
            div_cnt_q  <= div_cnt_d;
            div_rem_q  <= div_rem_d;
            div_quo_q  <= div_quo_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // mode control, blend, protection and gate drive
    localparam logic [6:0] REF_STARTUP_C = ref_gen_pkg::REF_STARTUP;
    localparam logic [6:0] BLEND_LAST_C  = ref_gen_pkg::BLEND_LAST;

    ref_gen_pkg::mode_t mode_q, mode_d;
    logic [23:0] st_cnt_q,  st_cnt_d;    // start-up sampling timer
    logic [6:0]  blend_q,   blend_d;     // blend weight in line cycles
    logic        ovp_q,     ovp_d;       // over-voltage lockout latched
    logic [23:0] ovp_cnt_q, ovp_cnt_d;   // time since last trip
    logic        kick_q,    kick_d;      // first switching cycle pending
    logic        gate_d;
    logic [6:0]  ref_d;
    logic        run;                    // switching allowed
    logic signed [15:0] diff, prod, mix;

    // next state of the control group
    always_comb begin
        mode_d    = mode_q;
        st_cnt_d  = st_cnt_q;
        blend_d   = blend_q;
        ovp_cnt_d = (ovp_cnt_q == 24'hFFFFFF) ? ovp_cnt_q : ovp_cnt_q + 24'h000001;
        ovp_d     = ovp_q;
        unique case (mode_q)
            ref_gen_pkg::ST_LOCKOUT: begin
                st_cnt_d = 24'h000000;
                if (stage_in.supply_ok) begin
                    mode_d = ref_gen_pkg::ST_STARTUP;
                end
            end
            ref_gen_pkg::ST_STARTUP: begin
                st_cnt_d = st_cnt_q + 24'h000001;
                if (st_cnt_q >= 24'(STARTUP_CYC - 1)) begin
                    blend_d = 7'h00;
                    if (!seen_q) begin
                        mode_d = ref_gen_pkg::ST_GROUNDED;
                    end else if (high_ok_q && per_cnt_q < 19'(LOSS_CYC)) begin
                        mode_d = ref_gen_pkg::ST_NORMAL;
                    end else begin
                        mode_d = ref_gen_pkg::ST_NOSENSE;
                    end
                end
            end
            ref_gen_pkg::ST_NORMAL: begin
                if ((fall && !fall_ok) || per_cnt_q >= 19'(LOSS_CYC)) begin
                    mode_d = ref_gen_pkg::ST_NOSENSE;
                end else if (fall && blend_q != BLEND_LAST_C) begin
                    blend_d = blend_q + 7'h01;
                end
            end
            ref_gen_pkg::ST_NOSENSE: begin
                // a good pulse brings the ramp back with a fresh blend
                if (fall_ok && per_cnt_q < 19'(LOSS_CYC)) begin
                    mode_d  = ref_gen_pkg::ST_NORMAL;
                    blend_d = 7'h00;
                end
            end
            ref_gen_pkg::ST_GROUNDED: begin
                mode_d = ref_gen_pkg::ST_GROUNDED;
            end
            default: begin
                mode_d = ref_gen_pkg::ST_LOCKOUT;
            end
        endcase
        if (!stage_in.supply_ok) begin
            mode_d = ref_gen_pkg::ST_LOCKOUT;
        end
        // a new trip wins over the release and restarts the timeout
        if (stage_in.ovp_trip) begin
            ovp_d     = 1'b1;
            ovp_cnt_d = 24'h000000;
        end else if (ovp_q && ovp_cnt_q >= 24'(OVP_TIMEOUT_CYC) && stage_in.ovp_release) begin
            ovp_d = 1'b0;
        end
        // gate: on at cycle start, off when current reaches the reference
        run = (mode_q != ref_gen_pkg::ST_LOCKOUT) && !stage_in.over_temp && !ovp_d;
        if (!run) begin
            gate_d = 1'b0;
        end else if (gate_drive_q) begin
            gate_d = !stage_in.current_trip;
        end else begin
            gate_d = stage_in.off_time_done | kick_q;
        end
        kick_d = !run ? 1'b1 : (gate_d ? 1'b0 : kick_q);
        // reference select, ramp weighted by blend until it is complete
        diff = $signed({9'h000, acc_q[14:8]}) - $signed({9'h000, REF_STARTUP_C});
        prod = diff * $signed({9'h000, blend_q});
        mix  = $signed({9'h000, REF_STARTUP_C}) + (prod >>> 7);
        unique case (mode_d)  // new mode's code lands on the very edge the mode changes
            ref_gen_pkg::ST_NORMAL: begin
                ref_d = (blend_q == BLEND_LAST_C) ? acc_q[14:8] : mix[6:0];
            end
            ref_gen_pkg::ST_NOSENSE:  ref_d = ref_gen_pkg::REF_NOSENSE;
            ref_gen_pkg::ST_GROUNDED: ref_d = ref_gen_pkg::REF_GROUNDED;
            default:                  ref_d = REF_STARTUP_C;
        endcase
    end

    // registers only; the code changes on the sample tick or a mode change
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_q       <= ref_gen_pkg::ST_LOCKOUT;
            st_cnt_q     <= 24'h000000;
            blend_q      <= 7'h00;
            ovp_q        <= 1'b0;
            ovp_cnt_q    <= 24'h000000;
            kick_q       <= 1'b1;
            gate_drive_q <= 1'b0;
            ref_code_q   <= ref_gen_pkg::REF_STARTUP;
        end else begin
            mode_q       <= mode_d;
            st_cnt_q     <= st_cnt_d;
            blend_q      <= blend_d;
            ovp_q        <= ovp_d;
            ovp_cnt_q    <= ovp_cnt_d;
            kick_q       <= kick_d;
            gate_drive_q <= gate_d;
            if (tick || mode_d != mode_q) begin
                ref_code_q <= ref_d;
            end
        end
    end

endmodule

// ### tb/ref_gen_chk.sv
module ref_gen_chk #(
    parameter int unsigned OVP_TIMEOUT_CYC = 1000
) (
    input wire logic                   clk_sys,
    input wire logic                   arst_n,
    input wire logic                   line_sense_input,
    input wire ref_gen_pkg::stage_in_t stage_in,
    input wire logic [6:0]             ref_code_q,
    input wire logic                   gate_drive_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////
    // cycles since the last over-voltage trip, saturating
    logic [31:0] age_q;
    logic [31:0] age_d;
    logic        wait_q; // trip seen, supply not yet back down
    logic        wait_d;
    // next values: a trip wins over a release in the same cycle
    always_comb begin
        age_d  = (age_q == 32'hFFFFFFFF) ? age_q : age_q + 32'h1;
        wait_d = stage_in.ovp_release ? 1'b0 : wait_q;
        if (stage_in.ovp_trip) begin
            age_d  = 32'h0;
            wait_d = 1'b1;
        end
    end
    // registers only; a reset forgets any trip, as the device does
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            age_q  <= 32'hFFFFFFFF;
            wait_q <= 1'b0;
        end else begin
            age_q  <= age_d;
            wait_q <= wait_d;
        end
    end
    ////////////////////////////////////////////////////////////
    a_trip_ends_on: assert property (gate_drive_q && stage_in.current_trip |=> !gate_drive_q)
        else $error("switch stayed on after current trip");
    a_heat_gate_low: assert property (stage_in.over_temp |=> !gate_drive_q)
        else $error("switch on during over temperature");
    a_ovp_gate_low: assert property (stage_in.ovp_trip |=> !gate_drive_q)
        else $error("switch on after over-voltage trip");
    a_ovp_timeout_hold: assert property (age_q >= 32'h1 && age_q <= OVP_TIMEOUT_CYC - 2 |-> !gate_drive_q)
        else $error("switch on before over-voltage timeout");
    a_ovp_release_wait: assert property (wait_q && $past(wait_q) |-> !gate_drive_q)
        else $error("switch on before supply fell back");
    a_lockout_state: assert property (!stage_in.supply_ok [*2] |=> ref_code_q == 7'h32 && !gate_drive_q)
        else $error("lockout did not give code 50 and gate low");
    a_on_needs_run: assert property ($rose(gate_drive_q) |-> $past(stage_in.supply_ok, 2)
                                     && !$past(stage_in.over_temp))
        else $error("switch turned on while not allowed to run");
    a_ref_floor: assert property (ref_code_q >= 7'h16)
        else $error("reference below ramp minimum");
    c_ovp_seen: cover property (stage_in.ovp_trip);
    c_nosense_code: cover property (ref_code_q == 7'h2A);
    c_switching: cover property ($rose(gate_drive_q));
endmodule

bind line_synced_reference_generator ref_gen_chk #(
    .OVP_TIMEOUT_CYC(OVP_TIMEOUT_CYC)
) ref_gen_chk_inst (
    .clk_sys          (clk_sys),
    .arst_n           (arst_n),
    .line_sense_input (line_sense_input),
    .stage_in         (stage_in),
    .ref_code_q       (ref_code_q),
    .gate_drive_q     (gate_drive_q)
);

// ### tb/power_stage_model.sv
module power_stage_model (
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic              gate_drive_q,
    input  wire logic [6:0]        ref_code_q,
    input  wire logic              slow,
    input  wire logic              supply_ok,
    input  wire logic              over_temp,
    input  wire logic              ovp_trip,
    input  wire logic              ovp_release,
    output ref_gen_pkg::stage_in_t stage_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] amps_q; // switch current in reference codes
    logic [7:0] amps_d;
    logic [4:0] off_q;  // off-time countdown
    logic [4:0] off_d;
    // current ramps only while on; slow mode mimics a large inductor
    always_comb begin
        amps_d = gate_drive_q ? amps_q + (slow ? 8'h01 : 8'h04) : 8'h00;
        off_d  = gate_drive_q ? 5'h14 : ((off_q == 5'h00) ? off_q : off_q - 5'h01);
    end
    // registers only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            amps_q <= 8'h00;
            off_q  <= 5'h00;
        end else begin
            amps_q <= amps_d;
            off_q  <= off_d;
        end
    end
    // comparators are levels; off-time stays done until the next on
    always_comb begin
        stage_in.supply_ok     = supply_ok;
        stage_in.current_trip  = gate_drive_q && (amps_q >= {1'b0, ref_code_q});
        stage_in.off_time_done = !gate_drive_q && (off_q == 5'h00);
        stage_in.over_temp     = over_temp;
        stage_in.ovp_trip      = ovp_trip;
        stage_in.ovp_release   = ovp_release;
    end
endmodule

// ### tb/test_line_synced_reference_generator.sv
module test_line_synced_reference_generator;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, arst_n, line_sense_input, slow, supply_ok, over_temp, ovp_trip, ovp_release;
    ref_gen_pkg::stage_in_t stage_in;
    logic [6:0] ref_code_q;
    logic       gate_drive_q;
    int         errors   = 0;
    int         compares = 0;
    int         rises;    // gate turn-ons in the last hold
    logic [6:0] lo;       // lowest code in the last hold
    logic [6:0] hi;       // highest code in the last hold
    logic       gate_was;
    ////////////////////////////////////////////////////////////
    // shortened counts keep the run near 100k cycles
    line_synced_reference_generator #(.STARTUP_CYC(2000), .MIN_HIGH_CYC(2000), .OVP_TIMEOUT_CYC(1000),
        .LOSS_CYC(5000)) line_synced_reference_generator_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .line_sense_input(line_sense_input), .stage_in(stage_in), .ref_code_q(ref_code_q),
        .gate_drive_q(gate_drive_q));
    power_stage_model power_stage_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .gate_drive_q(gate_drive_q),
        .ref_code_q(ref_code_q), .slow(slow), .supply_ok(supply_ok), .over_temp(over_temp),
        .ovp_trip(ovp_trip), .ovp_release(ovp_release), .stage_in(stage_in));
    ////////////////////////////////////////////////////////////
    // drive on the rising edge, look at the settled outputs on the falling one
    task automatic cyc(input logic ln);
        @(posedge clk_sys);
        line_sense_input <= ln;
        @(negedge clk_sys);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // hold the line level, gathering switching and reference extremes
    task automatic hold_line(input logic ln, input int n);
        rises = 0;
        lo    = 7'h7F;
        hi    = 7'h00;
        repeat (n) begin
            gate_was = gate_drive_q;
            cyc(ln);
            if (gate_drive_q && !gate_was) rises++;
            if (ref_code_q < lo) lo = ref_code_q;
            if (ref_code_q > hi) hi = ref_code_q;
        end
    endtask
    ////////////////////////////////////////////////////////////
    // grounded sense from power-up: start code, then fixed code for good
    task automatic grounded_mode();
        hold_line(1'b0, 200);
        check(32'(rises > 0), 32'h1);
        check({lo, hi}, {7'h32, 7'h32});
        hold_line(1'b0, 8000);
        check({lo, hi}, {7'h32, 7'h32});
    endtask
    // lockout, then wide pulses: gradual blend, peak centred in the window
    task automatic ramp_mode();
        logic [6:0] pk;
        logic [6:0] lim;
        int         t_first;
        int         t_last;
        @(posedge clk_sys);
        supply_ok <= 1'b0;
        cyc(1'b0);
        hold_line(1'b0, 10);
        check({rises[24:0], hi}, {25'h0, 7'h32});
        @(posedge clk_sys);
        supply_ok <= 1'b1;
        for (int n = 0; n < 14; n++) begin
            pk      = 7'h00;
            t_first = 0;
            t_last  = 0;
            lim     = 7'h33 + 7'((77 * (n + 1)) >> 7);
            for (int k = 0; k < 3700; k++) begin
                cyc(k < 2100);
                if (ref_code_q > pk) begin
                    pk      = ref_code_q;
                    t_first = k;
                end
                if (ref_code_q == pk) t_last = k;
                if (n == 13 && k == 1000) check(32'(ref_code_q < 7'h32), 32'h1);
            end
            check(32'(pk <= lim), 32'h1);
        end
        check(32'(pk > 7'h32), 32'h1);
        // filtered window spans 1501..3601, so its middle sits near 2551
        check(32'((t_first + t_last) / 2 > 2250 && (t_first + t_last) / 2 < 2850), 32'h1);
    endtask
    // narrow pulses, recovery, then a line that stops altogether
    task automatic sense_loss();
        hold_line(1'b1, 1600);
        hold_line(1'b0, 2100);
        hold_line(1'b1, 1600);
        check({lo, hi}, {7'h2A, 7'h2A});
        hold_line(1'b0, 2100);
        repeat (3) begin
            hold_line(1'b1, 2100);
            hold_line(1'b0, 1600);
        end
        check(32'(ref_code_q != 7'h2A), 32'h1);
        hold_line(1'b0, 6000);
        hold_line(1'b0, 500);
        check({lo, hi}, {7'h2A, 7'h2A});
    endtask
    // thermal and over-voltage holds against a slow power stage
    task automatic fault_hold();
        @(posedge clk_sys);
        slow      <= 1'b1;
        over_temp <= 1'b1;
        hold_line(1'b0, 300);
        check(rises, 0);
        @(posedge clk_sys);
        over_temp <= 1'b0;
        hold_line(1'b0, 300);
        check(32'(rises > 0), 32'h1);
        for (int r = 0; r < 2; r++) begin
            @(posedge clk_sys);
            ovp_trip <= 1'b1;
            @(posedge clk_sys);
            ovp_trip <= 1'b0;
            hold_line(1'b0, (r == 0) ? 1500 : 990);
            check(rises, 0);
            @(posedge clk_sys);
            ovp_release <= 1'b1;
            hold_line(1'b0, 200);
            check(32'(rises > 0), 32'h1);
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // watchdog: the sequence needs about 89k cycles, the limit stays under 100k
    initial begin
        #9_800_000;
        errors++;
        give_verdict();
    end
    initial begin
        arst_n = 1'b0;
        line_sense_input = 1'b0;
        slow = 1'b0;
        supply_ok = 1'b1;
        over_temp = 1'b0;
        ovp_trip = 1'b0;
        ovp_release = 1'b0;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        grounded_mode();
        ramp_mode();
        sense_loss();
        fault_hold();
        give_verdict();
    end
endmodule
